//--- verif/capture_compare_mode_select_tb_top.sv
// Bench: register port, capture edges, compare modes, interrupt gating.
// Assumes the pin model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_mode_select_tb_top;
	logic mclk, nrst, reg_write, ge, ae, irq;
	logic [1:0] reg_index;
	logic [7:0] reg_wdata, rd;
	logic [2:0] clr, match, pin, flag, cmp, pwm, wide, stb;
	int miscompares, compares, cycles;
	// Mode code, then expected and mask of compare, pwm, wide, flag
	localparam logic [15:0] MODES [8] = '{16'h489F, 16'h4C9F, 16'h469F,
		16'h4E9F, 16'h4257, 16'hC277, 16'h4A57, 16'h080F};
	capture_compare_mode_select uut (.mclk, .nrst, .reg_write, .reg_index,
		.reg_wdata, .reg_rdata_ff(rd), .flag_clear(clr), .match_event(match),
		.global_interrupt_enable(ge), .counter_array_interrupt_enable(ae),
		.module_external_pin(pin), .capture_strobe_ff(stb),
		.module_event_flag_ff(flag), .compare_active_ff(cmp),
		.pwm_active_ff(pwm), .wide_pwm_ff(wide), .interrupt_request_ff(irq));
	ccm_pin_model pins (.mclk, .pin);
	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard, far above the roughly 150 cycles the run needs
	always @(posedge mclk)
		if (++cycles == 2000) begin
			miscompares++;
			stop_test;
		end
	task stop_test;
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [1:0] i, input logic [7:0] d);
		@(negedge mclk) {reg_write, reg_index, reg_wdata} = {1'b1, i, d};
		@(negedge mclk) reg_write = 1'b0;
	endtask : wr
	// Mode for module 0, clear all flags, then one match pulse
	task strike(input logic [7:0] code);
		wr(2'h0, code);
		@(negedge mclk) clr = 3'h7;
		@(negedge mclk) {clr, match} = 6'h01;
		@(negedge mclk) match = 3'h0;
		@(negedge mclk);
	endtask : strike
	task t_regs;
		chk(rd, 8'h00);
		wr(2'h1, 8'hC2);
		wr(2'h3, 8'hFF);
		@(negedge mclk) reg_index = 2'h1;
		@(negedge mclk) chk(rd, 8'hC2);
		reg_index = 2'h3;
		@(negedge mclk) chk(rd, 8'h00);
		chk({6'h0, pwm[1], wide[1]}, 8'h03);
	endtask : t_regs
	task t_cap(input logic [7:0] code, input logic [1:0] e);
		strike(code);
		pins.set_pin(0, 1'b1);
		@(negedge mclk) chk({6'h0, stb[0], flag[0]}, {6'h0, e[0], e[0]});
		strike(code);
		pins.set_pin(0, 1'b0);
		@(negedge mclk) chk({6'h0, stb[0], flag[0]}, {6'h0, e[1], e[1]});
	endtask : t_cap
	task t_irq(input logic [7:0] code, input logic [1:0] en, input logic e);
		{ge, ae} = en;
		strike(code);
		chk({7'h0, irq}, {7'h0, e});
	endtask : t_irq
	initial begin
		{nrst, reg_write, reg_index, reg_wdata} = 12'h0;
		{clr, match, ge, ae} = 8'h03;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		t_regs;
		t_cap(8'h21, 2'b01);
		t_cap(8'h11, 2'b10);
		t_cap(8'hF1, 2'b11);
		t_cap(8'h29, 2'b00);
		for (int k = 0; k < 8; k++) begin
			strike(MODES[k][15:8]);
			chk({4'h0, MODES[k][3:0] & {cmp[0], pwm[0], wide[0], flag[0]}},
				{4'h0, MODES[k][7:4]});
		end
		for (int k = 0; k < 4; k++)
			t_irq(8'h49, 2'(k), k == 3);
		t_irq(8'h48, 2'b11, 1'b0);
		stop_test;
	end
endmodule : capture_compare_mode_select_tb_top
`default_nettype wire

//--- verif/ccm_chk.sv
// Checker of the mode-select outputs against their causes.
// Assumes one mclk domain; bound to every block instance.
`timescale 1ns/1ps
`default_nettype none
module ccm_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Watched ports
	input wire logic global_interrupt_enable,
	input wire logic counter_array_interrupt_enable,
	input wire logic [2:0] flag_clear,
	input wire logic [2:0] match_event,
	input wire logic [2:0] module_external_pin,
	input wire logic [2:0] capture_strobe_ff,
	input wire logic [2:0] module_event_flag_ff,
	input wire logic [2:0] pwm_active_ff,
	input wire logic [2:0] wide_pwm_ff,
	input wire logic interrupt_request_ff
);
	// Short names keep each property on one line
	wire logic en = global_interrupt_enable & counter_array_interrupt_enable;
	wire logic [2:0] pin = module_external_pin;
	wire logic [2:0] fl = module_event_flag_ff;
	wire logic [2:0] stb = capture_strobe_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_gate; interrupt_request_ff |-> $past(en); endproperty
	a_gate: assert property (p_gate) else $error("irq without enables");
	property p_cause; interrupt_request_ff |-> $past(|fl); endproperty
	a_cause: assert property (p_cause) else $error("irq without flag");
	property p_stb; (stb & ~fl) == 3'h0; endproperty
	a_stb: assert property (p_stb) else $error("capture without flag");
	property p_edge; (stb & ($past(pin) ~^ $past(pin, 2))) == 3'h0; endproperty
	a_edge: assert property (p_edge) else $error("capture without edge");
	property p_keep; ($past(fl & ~flag_clear) & ~fl) == 3'h0; endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_set; (fl & ~$past(fl | match_event) & ~stb) == 3'h0; endproperty
	a_set: assert property (p_set) else $error("flag without cause");
	property p_wide; (wide_pwm_ff & ~pwm_active_ff) == 3'h0; endproperty
	a_wide: assert property (p_wide) else $error("wide without pwm");
	property p_excl; (pwm_active_ff & stb) == 3'h0; endproperty
	a_excl: assert property (p_excl) else $error("capture in pwm");
endmodule : ccm_chk
// Every instance of the block gets its own checker
bind capture_compare_mode_select ccm_chk chk (.mclk, .nrst, .flag_clear,
	.global_interrupt_enable, .counter_array_interrupt_enable, .match_event,
	.module_external_pin, .capture_strobe_ff, .module_event_flag_ff,
	.pwm_active_ff, .wide_pwm_ff, .interrupt_request_ff);
`default_nettype wire

//--- verif/ccm_pin_model.sv
// Partner model: drives the external capture pin of each module.
// Assumes the bench moves one pin at a time through set_pin.
`timescale 1ns/1ps
`default_nettype none
module ccm_pin_model (
	// Clock and pin levels
	input wire logic mclk,
	output logic [2:0] pin
);
	// Idle low, so no stray edge is captured straight after reset
	initial pin = 3'h0;
	task set_pin(input int idx, input logic lvl);
		@(negedge mclk);
		pin[idx] = lvl;
	endtask : set_pin
endmodule : ccm_pin_model
`default_nettype wire

//--- verilog/capture_compare_mode_select.sv
// Mode selection and interrupt gating for a set of capture/compare modules.
// Assumes register writes arrive as a write strobe, module index and data,
// and the shared data path reports each module's match event.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Every module picks its own mode independently
// - Mode register bits 7 to 1 decoded to pick operation
// - Interrupt enable lets event flag request interrupt
// - Global and array enables also required
// - Rising-edge capture on positive field alone
// - Falling-edge capture on negative field alone
// - Both capture fields capture any transition
// - Comparator plus match gives software timer
// - Comparator, match, toggle give high-speed output
// - Comparator, toggle, pulse-width give frequency output
// - Comparator and pulse-width give 8-bit modulation
// - Adding wide select gives 16-bit modulation
module capture_compare_mode_select (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Mode register port
	input wire logic reg_write,
	input wire logic [1:0] reg_index,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_ff,
	// Flag clear from software, one bit per module
	input wire logic [ccm_pkg::NUM_MODULES-1:0] flag_clear,
	// Global enables
	input wire logic global_interrupt_enable,
	input wire logic counter_array_interrupt_enable,
	// Match events from the counter data path
	input wire logic [ccm_pkg::NUM_MODULES-1:0] match_event,
	// External pins
	input wire logic [ccm_pkg::NUM_MODULES-1:0] module_external_pin,
	// Status outputs
	output logic [ccm_pkg::NUM_MODULES-1:0] capture_strobe_ff,
	output logic [ccm_pkg::NUM_MODULES-1:0] module_event_flag_ff,
	output logic [ccm_pkg::NUM_MODULES-1:0] compare_active_ff,
	output logic [ccm_pkg::NUM_MODULES-1:0] pwm_active_ff,
	output logic [ccm_pkg::NUM_MODULES-1:0] wide_pwm_ff,
	output logic interrupt_request_ff
);
	import ccm_pkg::*;

	mode_reg_type mode_ff [NUM_MODULES];
	op_mode_type op_mode [NUM_MODULES];
	logic [NUM_MODULES-1:0] rise;
	logic [NUM_MODULES-1:0] fall;
	logic [NUM_MODULES-1:0] nxt_capture;
	logic [NUM_MODULES-1:0] nxt_event;
	logic [NUM_MODULES-1:0] nxt_flag;
	activity_type act [NUM_MODULES];
	logic nxt_irq;

	// Map a decoded mode to data-path activity
	function automatic activity_type activity_of(input op_mode_type m);
		activity_type a;
		a = '0;
		case (m)
			MODE_CAP_RISE, MODE_CAP_FALL, MODE_CAP_ANY: a.capture_active = 1'b1;
			MODE_SW_TIMER, MODE_HS_OUTPUT, MODE_FREQ_OUTPUT:
				a.compare_active = 1'b1;
			MODE_PWM8: a.pwm_active = 1'b1;
			MODE_WIDE_MODULATION_SELECT: begin
				a.pwm_active = 1'b1;
				a.wide_pwm = 1'b1;
			end
			default: a = '0;
		endcase
		return a;
	endfunction : activity_of

	// One decoder and edge detector per module, each on its own register
	for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
		ccm_mode_decode u_dec (
			.mode_reg(mode_ff[i]),
			.op_mode(op_mode[i])
		);
		ccm_edge_detect u_edge (
			.mclk(mclk),
			.nrst(nrst),
			.pin_in(module_external_pin[i]),
			.rise(rise[i]),
			.fall(fall[i])
		);
		assign act[i] = activity_of(op_mode[i]);
	end

	// Mode registers; each module written alone
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_MODULES; i++) mode_ff[i] <= MODE_RESET;
		end else if (reg_write && reg_index < 2'(NUM_MODULES)) begin
			mode_ff[reg_index] <= mode_reg_type'(reg_wdata);
		end
	end

	// Read-back of the selected mode register, zero for unmapped index
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) reg_rdata_ff <= 8'h00;
		else if (reg_index < 2'(NUM_MODULES)) reg_rdata_ff <= mode_ff[reg_index];
		else reg_rdata_ff <= 8'h00;
	end

	// Capture selection by edge and mode; events per module
	always_comb begin
		for (int i = 0; i < NUM_MODULES; i++) begin
			case (op_mode[i])
				MODE_CAP_RISE: nxt_capture[i] = rise[i];
				MODE_CAP_FALL: nxt_capture[i] = fall[i];
				MODE_CAP_ANY: nxt_capture[i] = rise[i] | fall[i];
				default: nxt_capture[i] = 1'b0;
			endcase
			// Match only counts in compare or modulation modes
			nxt_event[i] = nxt_capture[i] |
				(match_event[i] & (act[i].compare_active | act[i].pwm_active));
			// Set wins over a clear in the same cycle
			nxt_flag[i] = nxt_event[i] |
				(module_event_flag_ff[i] & ~flag_clear[i]);
		end
	end

	// Capture strobes, one cycle per captured edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) capture_strobe_ff <= '0;
		else capture_strobe_ff <= nxt_capture;
	end

	// Sticky event flags
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) module_event_flag_ff <= '0;
		else module_event_flag_ff <= nxt_flag;
	end

	// Activity outputs to the data path
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			compare_active_ff <= '0;
			pwm_active_ff <= '0;
			wide_pwm_ff <= '0;
		end else begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				compare_active_ff[i] <= act[i].compare_active;
				pwm_active_ff[i] <= act[i].pwm_active;
				wide_pwm_ff[i] <= act[i].wide_pwm;
			end
		end
	end

	// Interrupt: per-module enable gated by both global enables
	always_comb begin
		nxt_irq = 1'b0;
		for (int i = 0; i < NUM_MODULES; i++)
			nxt_irq = nxt_irq | (module_event_flag_ff[i] &
				mode_ff[i].module_interrupt_enable);
		nxt_irq = nxt_irq & global_interrupt_enable &
			counter_array_interrupt_enable;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) interrupt_request_ff <= 1'b0;
		else interrupt_request_ff <= nxt_irq;
	end
endmodule : capture_compare_mode_select
`default_nettype wire

//--- verilog/ccm_edge_detect.sv
// Edge detector for a module's external pin, used by capture modes.
// Assumes the pin is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module ccm_edge_detect (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Pin sample and edges
	input wire logic pin_in,
	output logic rise,
	output logic fall
);
	logic prev_ff;

	// Previous pin level
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) prev_ff <= 1'b0;
		else prev_ff <= pin_in;
	end

	assign rise = pin_in & ~prev_ff;
	assign fall = ~pin_in & prev_ff;
endmodule : ccm_edge_detect
`default_nettype wire

//--- verilog/ccm_mode_decode.sv
// Combinational mode decoder for one capture/compare module.
// Assumes the mode register is already held in flip-flops upstream.
`timescale 1ns/1ps
`default_nettype none
module ccm_mode_decode (
	// Register contents
	input wire ccm_pkg::mode_reg_type mode_reg,
	// Decoded mode
	output var ccm_pkg::op_mode_type op_mode
);
	import ccm_pkg::*;

	// Bits 7 to 1 decoded as one, interrupt enable bit ignored; unlisted codes fall to inactive
	always_comb begin
		op_mode = MODE_INACTIVE;
		if (mode_reg.positive_capture_enable || mode_reg.negative_capture_enable) begin
			if (!mode_reg.match_enable && !mode_reg.toggle_enable &&
			    !mode_reg.pulse_width_enable) begin
				case ({mode_reg.positive_capture_enable,
				       mode_reg.negative_capture_enable})
					2'b10: op_mode = MODE_CAP_RISE;
					2'b01: op_mode = MODE_CAP_FALL;
					default: op_mode = MODE_CAP_ANY;
				endcase
			end
		end else if (mode_reg.comparator_enable) begin
			if (mode_reg.pulse_width_enable && mode_reg.toggle_enable)
				op_mode = MODE_FREQ_OUTPUT;
			else if (mode_reg.pulse_width_enable)
				op_mode = mode_reg.wide_modulation_select ? MODE_WIDE_MODULATION_SELECT
					: MODE_PWM8;
			else if (mode_reg.match_enable && mode_reg.toggle_enable)
				op_mode = MODE_HS_OUTPUT;
			else if (mode_reg.match_enable)
				op_mode = MODE_SW_TIMER;
		end
	end
endmodule : ccm_mode_decode
`default_nettype wire

//--- verilog/ccm_pkg.sv
// Package for the capture/compare mode-select block: mode register layout,
// reset values and the decoded mode enumeration.
// Assumes a single 100 MHz system clock domain.
package ccm_pkg;
	// Bit positions in capture_compare_mode_n (bit7 down to bit0)
	localparam int WIDE_BIT = 7;
	localparam int COMP_BIT = 6;
	localparam int POSCAP_BIT = 5;
	localparam int NEGCAP_BIT = 4;
	localparam int MATCH_BIT = 3;
	localparam int TOGGLE_BIT = 2;
	localparam int PWM_BIT = 1;
	localparam int IRQEN_BIT = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int NUM_MODULES = 3;

	// Decoded fields of one mode register
	typedef struct packed {
		logic wide_modulation_select;
		logic comparator_enable;
		logic positive_capture_enable;
		logic negative_capture_enable;
		logic match_enable;
		logic toggle_enable;
		logic pulse_width_enable;
		logic module_interrupt_enable;
	} mode_reg_type;

	typedef enum logic [3:0] {
		MODE_INACTIVE,
		MODE_CAP_RISE,
		MODE_CAP_FALL,
		MODE_CAP_ANY,
		MODE_SW_TIMER,
		MODE_HS_OUTPUT,
		MODE_FREQ_OUTPUT,
		MODE_PWM8,
		MODE_WIDE_MODULATION_SELECT
	} op_mode_type;

	// Per-module activity summary handed to the data path
	typedef struct packed {
		logic capture_active;
		logic compare_active;
		logic pwm_active;
		logic wide_pwm;
	} activity_type;
endpackage : ccm_pkg
